/* design/eeprom_access_params.svh */
// offsets, field positions, reset values and timing for the data eeprom block
`ifndef EEPROM_ACCESS_PARAMS_SVH
`define EEPROM_ACCESS_PARAMS_SVH

// ==========================================================
// register byte offsets
`define NVM_CONTROL_OFFSET 12'h09C
`define NVM_LOCATION_OFFSET 12'h0A0
`define NVM_VALUE_OFFSET 12'h0A4
`define UNLOCK_KEY_OFFSET 12'h0A8
`define PERIPHERAL_FLAG_OFFSET 12'h0AC
`define NVM_STATUS_OFFSET 12'h0B0

// ==========================================================
// field positions
`define CTRL_READ_BIT 0
`define CTRL_STORE_BIT 1
`define CTRL_ALLOW_BIT 2
`define CTRL_ABORT_BIT 3
`define FLAG_DONE_BIT 7
`define STATUS_BUSY_BIT 0
`define STATUS_POWERUP_BIT 1
`define STATUS_PROTECT_BIT 2

// ==========================================================
// values and timing
`define UNLOCK_FIRST_KEY 8'h55
`define UNLOCK_SECOND_KEY 8'hAA
`define RESET_BYTE 8'h00
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_DECERR 2'h3
`define NVM_DEPTH 128
`define STORE_CYCLES 16
`define KEY_STEP_CYCLES 2
`define CLK_FREQ_HZ 25000000
`define POWERUP_TIME_MS 72
`define POWERUP_CYCLES (`POWERUP_TIME_MS * (`CLK_FREQ_HZ / 1000))

`endif

/* design/eeprom_access_pkg.sv */
// types shared by the data eeprom access block
package eeprom_access_pkg;

    // ==========================================================
    // unlock sequence progress, gray along the usual path
    typedef enum logic [1:0]
    {
        UNLOCK_IDLE = 2'h0,
        UNLOCK_GOT_FIRST = 2'h1,
        UNLOCK_GOT_SECOND = 2'h3
    } unlock_state_e;

    // ==========================================================
    // register selected by a bus address
    typedef enum logic [2:0]
    {
        SEL_NONE = 3'h0,
        SEL_CONTROL = 3'h1,
        SEL_LOCATION = 3'h2,
        SEL_VALUE = 3'h3,
        SEL_KEY = 3'h4,
        SEL_FLAG = 3'h5,
        SEL_STATUS = 3'h6
    } reg_sel_e;

endpackage

/* design/data_eeprom_access_control.sv */
// data eeprom access control with axi4-lite register slave
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "eeprom_access_params.svh"

module data_eeprom_access_control
#(
    parameter int unsigned DEPTH = `NVM_DEPTH,
    parameter int unsigned STORE_CYCLES = `STORE_CYCLES,
    parameter int unsigned KEY_STEP_CYCLES = `KEY_STEP_CYCLES,
    parameter int unsigned POWERUP_CYCLES = `POWERUP_CYCLES
)
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic ce_in,
    input wire logic [11:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [11:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic master_reset_pin_in,
    input wire logic watchdog_reset_in,
    input wire logic brownout_reset_in,
    input wire logic code_protect_in
);

    localparam int ADDR_W = $clog2(DEPTH);
    localparam int SC_W = $clog2(STORE_CYCLES + 1);
    localparam int PWR_W = $clog2(POWERUP_CYCLES + 1);
    localparam logic [7:0] STEP_COUNT = 8'(KEY_STEP_CYCLES);

    // ==========================================================
    // address decode, shared by both bus directions
    function automatic eeprom_access_pkg::reg_sel_e reg_decode(
        input logic [11:0] addr);
        case (addr)
            `NVM_CONTROL_OFFSET: reg_decode = eeprom_access_pkg::SEL_CONTROL;
            `NVM_LOCATION_OFFSET: reg_decode = eeprom_access_pkg::SEL_LOCATION;
            `NVM_VALUE_OFFSET: reg_decode = eeprom_access_pkg::SEL_VALUE;
            `UNLOCK_KEY_OFFSET: reg_decode = eeprom_access_pkg::SEL_KEY;
            `PERIPHERAL_FLAG_OFFSET: reg_decode = eeprom_access_pkg::SEL_FLAG;
            `NVM_STATUS_OFFSET: reg_decode = eeprom_access_pkg::SEL_STATUS;
            default: reg_decode = eeprom_access_pkg::SEL_NONE;
        endcase
    endfunction

    // ==========================================================
    // state
    logic [7:0] mem [DEPTH];
    logic [3:0] sync_meta;
    logic [3:0] sync_hold;
    logic aw_full;
    logic [11:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic w_strb0;
    logic read_launch;
    logic store_launch;
    logic store_allow;
    logic store_abort_flag;
    logic store_done_flag;
    logic [ADDR_W-1:0] nvm_location_reg;
    logic [7:0] nvm_value_reg;
    logic [ADDR_W-1:0] store_addr;
    logic [7:0] store_data;
    logic [SC_W-1:0] store_cnt;
    logic [PWR_W-1:0] pwr_cnt;
    logic [7:0] step_cnt;
    eeprom_access_pkg::unlock_state_e unlock_state;
    eeprom_access_pkg::reg_sel_e wsel;
    logic wr_do;
    logic [7:0] wbyte;
    logic ctrl_wr;
    logic key_wr;
    logic any_reset;
    logic powerup_running;
    logic first_ok;
    logic launch_ok;
    logic start_store;
    logic store_finish;
    logic abort_now;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    // ==========================================================
    // reset and strap synchronisers
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            sync_meta <= 4'h0;
            sync_hold <= 4'h0;
        end
        else if (ce_in)
        begin
            sync_meta <= {code_protect_in, brownout_reset_in,
                watchdog_reset_in, master_reset_pin_in};
            sync_hold <= sync_meta;
        end
    end

    // watchdog input is meant to carry resets, not sleep wake-ups
    assign any_reset = sync_hold[0] | sync_hold[1] | sync_hold[2];

    // ==========================================================
    // axi write channels, address and data taken in either order
    assign s_axi_awready_out = ce_in & ~aw_full;
    assign s_axi_wready_out = ce_in & ~w_full;
    assign wr_do = aw_full & w_full & ~s_axi_bvalid_out;
    assign wsel = reg_decode(aw_addr);
    assign wbyte = w_data[7:0];
    assign ctrl_wr = wr_do & w_strb0
        & (wsel == eeprom_access_pkg::SEL_CONTROL);
    assign key_wr = wr_do & w_strb0 & (wsel == eeprom_access_pkg::SEL_KEY);

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            aw_full <= 1'b0;
            aw_addr <= 12'h000;
            w_full <= 1'b0;
            w_data <= 32'h00000000;
            w_strb0 <= 1'b0;
        end
        else if (ce_in)
        begin
            if (s_axi_awvalid_in && !aw_full)
            begin
                aw_full <= 1'b1;
                aw_addr <= s_axi_awaddr_in;
            end
            else if (wr_do)
            begin
                aw_full <= 1'b0;
            end
            if (s_axi_wvalid_in && !w_full)
            begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata_in;
                w_strb0 <= s_axi_wstrb_in[0];
            end
            else if (wr_do)
            begin
                w_full <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= `AXI_RESP_OKAY;
        end
        else if (ce_in)
        begin
            if (wr_do)
            begin
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out <= (wsel == eeprom_access_pkg::SEL_NONE) ?
                    `AXI_RESP_DECERR : `AXI_RESP_OKAY;
            end
            else if (s_axi_bready_in)
            begin
                s_axi_bvalid_out <= 1'b0;
            end
        end
    end

    // ==========================================================
    // axi read channel, one cycle to rvalid
    assign s_axi_arready_out = ce_in & ~s_axi_rvalid_out;

    always_comb
    begin
        next_rdata = 32'h00000000;
        next_rresp = `AXI_RESP_OKAY;
        case (reg_decode(s_axi_araddr_in))
            eeprom_access_pkg::SEL_CONTROL:
                next_rdata[3:0] = {store_abort_flag, store_allow,
                    store_launch, read_launch};
            eeprom_access_pkg::SEL_LOCATION:
                next_rdata[ADDR_W-1:0] = nvm_location_reg;
            eeprom_access_pkg::SEL_VALUE:
                next_rdata[7:0] = nvm_value_reg;
            eeprom_access_pkg::SEL_KEY:
                next_rdata = 32'h00000000;
            eeprom_access_pkg::SEL_FLAG:
                next_rdata[`FLAG_DONE_BIT] = store_done_flag;
            eeprom_access_pkg::SEL_STATUS:
                next_rdata[2:0] = {sync_hold[3], powerup_running,
                    store_launch};
            default:
                next_rresp = `AXI_RESP_DECERR;
        endcase
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h00000000;
            s_axi_rresp_out <= `AXI_RESP_OKAY;
        end
        else if (ce_in)
        begin
            if (s_axi_arvalid_in && !s_axi_rvalid_out)
            begin
                s_axi_rvalid_out <= 1'b1;
                s_axi_rdata_out <= next_rdata;
                s_axi_rresp_out <= next_rresp;
            end
            else if (s_axi_rready_in)
            begin
                s_axi_rvalid_out <= 1'b0;
            end
        end
    end

    // ==========================================================
    // power-up timer
    assign powerup_running = (pwr_cnt != '0);

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            pwr_cnt <= PWR_W'(POWERUP_CYCLES);
        end
        else if (ce_in && powerup_running)
        begin
            pwr_cnt <= pwr_cnt - PWR_W'(1);
        end
    end

    // ==========================================================
    // unlock sequence and its cycle count
    assign first_ok = (unlock_state == eeprom_access_pkg::UNLOCK_GOT_FIRST)
        && (step_cnt == STEP_COUNT);
    assign launch_ok = (unlock_state == eeprom_access_pkg::UNLOCK_GOT_SECOND)
        && (step_cnt == STEP_COUNT);

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            unlock_state <= eeprom_access_pkg::UNLOCK_IDLE;
        end
        else if (ce_in && wr_do)
        begin
            // any other write breaks the sequence
            case (unlock_state)
                eeprom_access_pkg::UNLOCK_IDLE,
                eeprom_access_pkg::UNLOCK_GOT_FIRST,
                eeprom_access_pkg::UNLOCK_GOT_SECOND:
                    if (key_wr && wbyte == `UNLOCK_FIRST_KEY)
                        unlock_state <= eeprom_access_pkg::UNLOCK_GOT_FIRST;
                    else if (key_wr && wbyte == `UNLOCK_SECOND_KEY && first_ok)
                        unlock_state <= eeprom_access_pkg::UNLOCK_GOT_SECOND;
                    else
                        unlock_state <= eeprom_access_pkg::UNLOCK_IDLE;
                default:
                    unlock_state <= eeprom_access_pkg::UNLOCK_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            step_cnt <= 8'h00;
        end
        else if (ce_in)
        begin
            if (key_wr)
                step_cnt <= 8'h01;
            else if (step_cnt != 8'hFF)
                step_cnt <= step_cnt + 8'h01;
        end
    end

    // ==========================================================
    // store cycle
    // allow must already be set; blocked by power-up timer
    assign start_store = ctrl_wr & wbyte[`CTRL_STORE_BIT] & store_allow
        & launch_ok & ~store_launch & ~powerup_running & ~any_reset;
    assign store_finish = store_launch & (store_cnt == '0) & ~any_reset;
    assign abort_now = store_launch & any_reset;

    // launch bit stays up for the whole store
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            store_launch <= 1'b0;
            store_cnt <= '0;
            store_addr <= '0;
            store_data <= `RESET_BYTE;
        end
        else if (ce_in)
        begin
            // only completion or a reset ends a store
            if (abort_now || store_finish)
            begin
                store_launch <= 1'b0;
            end
            else if (start_store)
            begin
                store_launch <= 1'b1;
                store_cnt <= SC_W'(STORE_CYCLES - 1);
                store_addr <= nvm_location_reg;
                store_data <= nvm_value_reg;
            end
            else if (store_launch)
            begin
                store_cnt <= store_cnt - SC_W'(1);
            end
        end
    end

    // protection does not gate or scramble the array
    always_ff @(posedge clk_in)
    begin
        if (ce_in && store_finish)
            mem[store_addr] <= store_data;
    end

    // ==========================================================
    // control and flag bits
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            store_allow <= 1'b0;
            store_abort_flag <= 1'b0;
            read_launch <= 1'b0;
            store_done_flag <= 1'b0;
        end
        else if (ce_in)
        begin
            if (ctrl_wr)
                store_allow <= wbyte[`CTRL_ALLOW_BIT];
            // reset during a store wins over a software clear
            if (abort_now)
                store_abort_flag <= 1'b1;
            else if (store_finish)
                store_abort_flag <= 1'b0;
            else if (ctrl_wr)
                store_abort_flag <= wbyte[`CTRL_ABORT_BIT];
            // read lasts one cycle; zero never clears
            if (read_launch)
                read_launch <= 1'b0;
            else if (ctrl_wr && wbyte[`CTRL_READ_BIT])
                read_launch <= 1'b1;
            // done sets; set wins over software clear
            if (store_finish)
                store_done_flag <= 1'b1;
            else if (wr_do && w_strb0 && wsel == eeprom_access_pkg::SEL_FLAG)
                store_done_flag <= wbyte[`FLAG_DONE_BIT];
        end
    end

    // fetch lands next cycle; held until read or write
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            nvm_value_reg <= `RESET_BYTE;
            nvm_location_reg <= '0;
        end
        else if (ce_in)
        begin
            if (read_launch)
                nvm_value_reg <= mem[nvm_location_reg];
            else if (wr_do && w_strb0 && wsel == eeprom_access_pkg::SEL_VALUE)
                nvm_value_reg <= wbyte;
            if (wr_do && w_strb0 && wsel == eeprom_access_pkg::SEL_LOCATION)
                nvm_location_reg <= w_data[ADDR_W-1:0];
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    a_read_one_cycle: assert property (ce_in && read_launch |=>
        !read_launch)
        else $error("read launch stayed set");
    a_read_fetch: assert property (ce_in && read_launch |=>
        nvm_value_reg == $past(mem[nvm_location_reg]))
        else $error("value register missed fetched byte");
    a_store_needs_allow: assert property ($rose(store_launch) |->
        $past(store_allow))
        else $error("store started without allow");
    a_store_needs_keys: assert property ($rose(store_launch) |->
        $past(unlock_state) == eeprom_access_pkg::UNLOCK_GOT_SECOND
        && $past(step_cnt) == STEP_COUNT)
        else $error("store started without exact key sequence");
    a_allow_kept: assert property (ce_in && !ctrl_wr && store_allow |=>
        store_allow)
        else $error("allow cleared by hardware");
    a_store_persists: assert property (ce_in && store_launch
        && !any_reset && store_cnt != '0 |=> store_launch)
        else $error("store ended early");
    a_store_done: assert property (ce_in && store_finish |=>
        store_done_flag && !store_launch && !store_abort_flag)
        else $error("completion not flagged");
    a_done_sticky: assert property (store_done_flag && !wr_do |=>
        store_done_flag)
        else $error("done flag lost");
    a_abort_flag: assert property (ce_in && abort_now |=>
        store_abort_flag && !store_launch)
        else $error("abort not flagged");
    a_powerup_block: assert property (powerup_running |=>
        !$rose(store_launch))
        else $error("store during power-up timer");
    a_store_length: assert property ($rose(store_launch) && ce_in
        && !any_reset |-> store_cnt == SC_W'(STORE_CYCLES - 1))
        else $error("store length wrong");

    c_read: cover property (ce_in && read_launch ##1 s_axi_rvalid_out);
    c_store: cover property ($rose(store_launch) ##[1:64] store_finish);
    c_abort: cover property (abort_now);
    c_key_reject: cover property (key_wr && wbyte == `UNLOCK_SECOND_KEY
        && !first_ok);

endmodule // data_eeprom_access_control

/* tb/tb.sv */
// self-checking bench for the data eeprom access control block
`timescale 1ns/1ps
`include "eeprom_access_params.svh"
`define CHK(nm, ex, gt) \
    begin \
        checks++; \
        if ((gt) !== (ex)) \
        begin \
            num_errors++; \
            $display("[ERR] %s exp %h got %h", nm, ex, gt); \
        end \
    end

module tb;
    localparam int unsigned STORE_N = 40;
    localparam logic [11:0] CTRL = `NVM_CONTROL_OFFSET;
    localparam logic [11:0] LOC = `NVM_LOCATION_OFFSET;
    localparam logic [11:0] VAL = `NVM_VALUE_OFFSET;
    localparam logic [11:0] KEY = `UNLOCK_KEY_OFFSET;
    localparam logic [11:0] FLAG = `PERIPHERAL_FLAG_OFFSET;
    localparam logic [11:0] STAT = `NVM_STATUS_OFFSET;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [2:0] rsrc = 3'h0;
    logic cp = 1'b0;
    logic ce = 1'b1;
    logic [3:0] strb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, rd;
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;

    // ==========================================================
    // clock, timeout and closing report
    initial
    begin
        forever #20 clk_in = ~clk_in;
    end

    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ==========================================================
    // bus master, bready and rready held high throughout
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic ta;
        logic tw;
        logic da;
        logic dw;
        da = 1'b0;
        dw = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(da && dw))
        begin
            @(negedge clk_in);
            ta = awvalid && awready;
            tw = wvalid && wready;
            @(posedge clk_in);
            if (ta)
                awvalid <= 1'b0;
            if (tw)
                wvalid <= 1'b0;
            da = da | ta;
            dw = dw | tw;
        end
        do @(negedge clk_in); while (!bvalid);
        rs = bresp;
        @(posedge clk_in);
    endtask

    task automatic rdr(input logic [11:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do @(negedge clk_in); while (!arready);
        @(posedge clk_in);
        arvalid <= 1'b0;
        do @(negedge clk_in); while (!rvalid);
        rd = rdata;
        rs = rresp;
        @(posedge clk_in);
    endtask

    // allow, two keys (gap idle cycles apart), then control write c
    task automatic seq(input logic [7:0] l, v, k1, k2, input logic [31:0] c,
                       input int gap);
        wr(LOC, {24'h0, l});
        wr(VAL, {24'h0, v});
        wr(CTRL, c & 32'h4);
        wr(KEY, {24'h0, k1});
        repeat (gap) @(posedge clk_in);
        wr(KEY, {24'h0, k2});
        wr(CTRL, c);
    endtask

    task automatic wait_idle();
        do rdr(CTRL); while (rd[1] !== 1'b0);
    endtask

    task automatic ee_read(input logic [7:0] l, input logic [7:0] ex);
        wr(LOC, {24'h0, l});
        wr(CTRL, 32'h1);
        rdr(CTRL);
        `CHK("read launch", 1'b0, rd[0])
        rdr(VAL);
        `CHK("value", ex, rd[7:0])
        rdr(VAL);
        `CHK("value held", ex, rd[7:0])
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset();
        rdr(CTRL);
        `CHK("ctrl reset", 32'h0, rd)
        rdr(STAT);
        `CHK("powerup busy", 1'b1, rd[1])
        rdr(12'h0F0);
        `CHK("unmapped rresp", `AXI_RESP_DECERR, rs)
        `CHK("unmapped rdata", 32'h0, rd)
        wr(12'h0F0, 32'h1);
        `CHK("unmapped bresp", `AXI_RESP_DECERR, rs)
    endtask

    task automatic t_powerup();
        seq(8'h05, 8'h3C, 8'h55, 8'hAA, 32'h6, 0);
        wait_idle();
        rdr(FLAG);
        `CHK("done in powerup", 1'b0, rd[7])
        do rdr(STAT); while (rd[1] !== 1'b0);
    endtask

    task automatic t_abort();
        for (int s = 0; s < 3; s++)
        begin
            seq(8'h30, 8'h77, 8'h55, 8'hAA, 32'h6, 0);
            rsrc <= 3'h1 << s;
            repeat (4) @(posedge clk_in);
            rsrc <= 3'h0;
            repeat (4) @(posedge clk_in);
            rdr(CTRL);
            // abort set, allow kept
            `CHK("ctrl after cut", 4'hC, rd[3:0])
        end
    endtask

    task automatic t_store();
        // abort bit set by software, so completion must clear it
        seq(8'h12, 8'hA5, 8'h55, 8'hAA, 32'hE, 0);
        rdr(CTRL);
        `CHK("launch busy", 1'b1, rd[1])
        wait_idle();
        rdr(CTRL);
        `CHK("ctrl done", 4'h4, rd[3:0])
        repeat (20) @(posedge clk_in);
        rdr(FLAG);
        `CHK("done flag", 1'b1, rd[7])
        wr(FLAG, 32'h0);
        rdr(FLAG);
        `CHK("done cleared", 1'b0, rd[7])
        ee_read(8'h12, 8'hA5);
    endtask

    task automatic t_allow_drop();
        seq(8'h20, 8'h5A, 8'h55, 8'hAA, 32'h6, 0);
        wr(CTRL, 32'h4);
        rdr(CTRL);
        `CHK("zero write", 1'b1, rd[1])
        wr(CTRL, 32'h0);
        wait_idle();
        `CHK("allow off", 1'b0, rd[2])
        ee_read(8'h20, 8'h5A);
    endtask

    task automatic t_refused();
        logic [7:0] k1 [4] = '{8'hAA, 8'h55, 8'h55, 8'h55};
        logic [7:0] k2 [4] = '{8'h55, 8'h55, 8'hAA, 8'hAA};
        logic [31:0] c [4] = '{32'h6, 32'h6, 32'h2, 32'h6};
        int g [4] = '{0, 0, 0, 1};
        for (int i = 0; i < 4; i++)
        begin
            seq(8'h12, 8'h11, k1[i], k2[i], c[i], g[i]);
            rdr(CTRL);
            `CHK("no launch", 1'b0, rd[1])
            ee_read(8'h12, 8'hA5);
        end
    endtask

    task automatic t_protect();
        cp <= 1'b1;
        repeat (4) @(posedge clk_in);
        rdr(STAT);
        `CHK("protect", 1'b1, rd[2])
        seq(8'h44, 8'hC3, 8'h55, 8'hAA, 32'h6, 0);
        wait_idle();
        ee_read(8'h44, 8'hC3);
        cp <= 1'b0;
    endtask

    // clock enable low freezes a running store; masked byte lane ignored
    task automatic t_gate();
        seq(8'h50, 8'h99, 8'h55, 8'hAA, 32'h6, 0);
        ce <= 1'b0;
        repeat (60) @(posedge clk_in);
        `CHK("ready frozen", 1'b0, awready)
        ce <= 1'b1;
        @(posedge clk_in);
        rdr(CTRL);
        `CHK("store frozen", 1'b1, rd[1])
        wait_idle();
        strb <= 4'h0;
        wr(VAL, 32'h11);
        strb <= 4'hF;
        rdr(VAL);
        `CHK("masked write", 8'h99, rd[7:0])
    endtask

    // ==========================================================
    // device under test, short powerup time, longer store time
    data_eeprom_access_control #(
        .STORE_CYCLES(STORE_N),
        .KEY_STEP_CYCLES(3),
        .POWERUP_CYCLES(200)
    ) dut (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .ce_in(ce),
        .s_axi_awaddr_in(awaddr),
        .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(strb),
        .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(1'b1),
        .s_axi_araddr_in(araddr),
        .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(1'b1),
        .master_reset_pin_in(rsrc[0]),
        .watchdog_reset_in(rsrc[1]),
        .brownout_reset_in(rsrc[2]),
        .code_protect_in(cp)
    );

    initial
    begin
        repeat (10) @(posedge clk_in);
        reset_n_in <= 1'b1;
        @(posedge clk_in);
        t_reset();
        t_powerup();
        t_abort();
        t_store();
        t_allow_drop();
        t_refused();
        t_protect();
        t_gate();
        wrap_up();
    end
endmodule // tb
